// file: fecs_bus_cycle.sv
`timescale 1ns/1ps
`include "fecs_params.svh"
// one bus cycle on the flash pins: write pulse or read
module fecs_bus_cycle
  import fecs_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
)(
  input  wire logic          i_clk_sys,    // system clock
  input  wire logic          i_rstn,       // async reset, low
  input  wire logic          i_ce,         // clock enable
  input  wire logic          i_go,         // start a cycle
  input  wire logic          i_rd,         // 1 read, 0 write
  input  wire logic [AW-1:0] i_addr,       // cycle address
  input  wire logic [DW-1:0] i_data,       // write data
  input  wire logic [DW-1:0] i_dq_in,      // data pins in
  output logic               o_busy,       // cycle running
  output logic               o_done,       // one-cycle end pulse
  output logic [DW-1:0]      o_rdata,      // captured read data
  output logic [AW-1:0]      o_addr,       // address pins
  output logic [DW-1:0]      o_dq_out,     // data pins out
  output logic               o_dq_oe,      // data pins driven
  output logic               o_we_n,       // write enable, low
  output logic               o_oe_n        // output enable, low
);
  typedef struct packed {
    logic          busy;
    logic          done;
    logic          rd;
    logic          hi;
    logic [3:0]    cnt;
    logic [DW-1:0] rdata;
    logic [AW-1:0] addr;
    logic [DW-1:0] dout;
    logic          oe;
    logic          we_n;
    logic          oe_n;
  } fecs_bc_t;
  fecs_bc_t s_r, s_nxt;

  // low phase then recovery phase; read samples at end of strobe
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy)
    begin
      if (i_go)
      begin
        s_nxt.busy = 1'b1;
        s_nxt.rd   = i_rd;
        s_nxt.hi   = 1'b0;
        s_nxt.addr = i_addr;
        s_nxt.dout = i_data;
        s_nxt.oe   = ~i_rd;
        s_nxt.we_n = i_rd;
        s_nxt.oe_n = ~i_rd;
        s_nxt.cnt  = i_rd ? 4'(`FECS_RD_CYC) : 4'(`FECS_WE_LOW_CYC);
      end
    end
    else if (s_r.cnt > 4'h1)
      s_nxt.cnt = s_r.cnt - 4'h1;
    else if (!s_r.hi)
    begin
      // rising write edge latches the data in the device
      s_nxt.hi    = 1'b1;
      s_nxt.we_n  = 1'b1;
      s_nxt.oe_n  = 1'b1;
      s_nxt.cnt   = 4'(`FECS_WE_HIGH_CYC);
      if (s_r.rd)
        s_nxt.rdata = i_dq_in;
    end
    else
    begin
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b1;
      s_nxt.oe   = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_r      <= '0;
      s_r.we_n <= 1'b1;
      s_r.oe_n <= 1'b1;
    end
    else if (i_ce)
      s_r <= s_nxt;
  end

  assign o_busy   = s_r.busy;
  assign o_done   = s_r.done;
  assign o_rdata  = s_r.rdata;
  assign o_addr   = s_r.addr;
  assign o_dq_out = s_r.dout;
  assign o_dq_oe  = s_r.oe;
  assign o_we_n   = s_r.we_n;
  assign o_oe_n   = s_r.oe_n;
endmodule : fecs_bus_cycle

// file: fecs_flash_model.sv
`timescale 1ns/1ps
// behavioural flash device on the host pins
module fecs_flash_model #(
  parameter int         WIN_NS    = 3200,
  parameter int         ER_NS     = 4000,
  parameter logic [6:0] PROT_SECT = 7'h0C
)(
  input  wire logic [21:0] i_addr, // address pins
  input  wire logic [15:0] i_dq,   // data from host
  input  wire logic        i_we_n, // write enable
  input  wire logic        i_oe_n, // output enable
  output logic      [15:0] o_dq    // data to host
);
  logic [21:0] wa[$];
  logic [15:0] wd[$];
  logic [21:0] ra[$];
  bit   [127:0] pend;
  bit          win, ers, susp, ident, setup, tog;
  bit   [1:0]  ul;
  bit   [15:0] rdat, last;
  time         t_win, t_er;
  // command decode on each write-enable rising edge
  always @(posedge i_we_n)
  begin
    wa.push_back(i_addr);
    wd.push_back(i_dq);
    if (ers && !susp) susp = (i_dq[7:0] == 8'hB0); // only suspend acts
    else if (win && i_dq[7:0] == 8'h30)
    begin
      pend[i_addr[21:15]] = 1'b1; // add sector, restart window
      t_win = $time;
    end
    else if (win)
    begin
      susp = (i_dq[7:0] == 8'hB0); // suspend ends window at once
      ers = susp;
      if (!susp) pend = '0; // any other command drops the erase
      win = 1'b0;
    end
    else if (susp && ul == 2'd0 && i_dq[7:0] == 8'h30)
    begin
      susp = 1'b0; // resume; repeats fall into the busy branch
      t_er = $time;
    end
    else if (ul == 2'd0)
    begin
      ul = {1'b0, i_addr[11:0] == 12'h555 && i_dq[7:0] == 8'hAA}; // low bits only
      ident = ident && i_dq[7:0] != 8'h00; // final 00 leaves id mode
    end
    else if (ul == 2'd1)
      ul = (i_addr[11:0] == 12'h2AA && i_dq[7:0] == 8'h55) ? 2'd2 : 2'd0;
    else
    begin
      ul = 2'd0;
      win = setup && i_dq[7:0] == 8'h30; // window from this rising edge
      t_win = $time;
      if (win) pend[i_addr[21:15]] = 1'b1;
      setup = i_dq[7:0] == 8'h80;
      ident = i_dq[7:0] == 8'h90; // id mode, also while suspended
    end
  end
  // window expiry and erase progress, no preprogram from host
  always #100
  begin
    if (win && $time - t_win >= WIN_NS)
    begin
      win = 1'b0;
      ers = 1'b1;
      t_er = $time;
    end
    if (ers && !susp && $time - t_er >= ER_NS)
    begin
      ers = 1'b0; // back to array reads
      pend = '0;
    end
  end
  // read answer at the start of the strobe
  always @(negedge i_oe_n)
  begin
    ra.push_back(i_addr);
    tog = !tog;
    if ((win || ers) && pend[i_addr[21:15]])
      rdat = {8'h00, 1'b0, tog, 2'b00, !win, tog, 2'b00}; // status bits
    else if (ident && i_addr[11:0] == 12'h002)
      rdat = {15'h0000, i_addr[21:15] == PROT_SECT}; // group protect answer
    else
      rdat = i_addr[15:0] ^ 16'h5A5A;
  end
  // released pins show the inverse of the last value
  always @(posedge i_oe_n) last = rdat;
  assign o_dq = i_oe_n ? ~last : rdat;
endmodule : fecs_flash_model

// file: fecs_host.sv
`timescale 1ns/1ps
`include "fecs_params.svh"
module fecs_host
  import fecs_pkg::*;
#(
  parameter int AW      = 22,
  parameter int DW      = 16,
  parameter int GAP_CYC = `FECS_GAP_CYC
)(
  input  wire logic          i_clk_sys,    // system clock 25 MHz
  input  wire logic          i_rstn,       // async reset, low
  input  wire logic          i_ce,         // clock enable
  input  wire logic          i_req,        // operation request
  input  wire fecs_op_t      i_op,         // operation code
  input  wire logic [AW-1:0] i_addr,       // sector or program address
  input  wire logic [DW-1:0] i_wdata,      // program word or word count
  input  wire logic [DW-1:0] i_dq_in,      // flash data pins in
  output logic               o_ready,      // accepts a request
  output logic               o_done,       // operation finished pulse
  output logic               o_late,       // add-sector spacing exceeded
  output logic [DW-1:0]      o_rdata,      // last read data
  output logic               o_window,     // add-sector window believed open
  output logic [AW-1:0]      o_flash_addr, // flash address pins
  output logic [DW-1:0]      o_dq_out,     // flash data out
  output logic               o_dq_oe,      // flash data driven
  output logic               o_we_n,       // flash write enable
  output logic               o_oe_n        // flash output enable
);
  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_FIN} fecs_st_t;
  typedef struct packed {
    fecs_st_t      st;
    fecs_op_t      op;
    logic [2:0]    idx;     // cycle in sequence
    logic [2:0]    len;     // cycles in sequence
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [15:0]   gap;     // cycles since last sector write
    logic          win;
    logic          late;
    logic          done;
    logic [DW-1:0] rdata;
    logic          rdy;     // idle, registered for the ready output
  } fecs_host_t;
  fecs_host_t s_r, s_nxt;

  logic          bc_go;
  logic          bc_rd;
  logic [AW-1:0] bc_addr;
  logic [DW-1:0] bc_data;
  logic          bc_done;
  logic [DW-1:0] bc_rdata;

  // sequence table: address and data of cycle idx for the held op
  always_comb
  begin
    logic [11:0] ua;
    logic [7:0]  ud;
    logic        raw;
    ua      = `FECS_ADDR_ANY;
    ud      = `FECS_D_ZERO;
    raw     = 1'b0;   // full address from user, not unlock
    bc_rd   = 1'b0;   // command cycles are writes
    bc_data = '0;
    case (s_r.op)
      FECS_OP_ERASE:
        case (s_r.idx)
          3'd0: begin ua = `FECS_ADDR_UNLOCK1; ud = `FECS_D_UNLOCK1; end
          3'd1: begin ua = `FECS_ADDR_UNLOCK2; ud = `FECS_D_UNLOCK2; end
          3'd2: begin ua = `FECS_ADDR_UNLOCK1; ud = `FECS_D_ERASE_SETUP; end
          3'd3: begin ua = `FECS_ADDR_UNLOCK1; ud = `FECS_D_UNLOCK1; end
          3'd4: begin ua = `FECS_ADDR_UNLOCK2; ud = `FECS_D_UNLOCK2; end
          default: begin raw = 1'b1; ud = `FECS_D_SECT_ERASE; end
        endcase
      FECS_OP_ADD_SECT:   begin raw = 1'b1; ud = `FECS_D_SECT_ERASE; end
      FECS_OP_SUSPEND:    ud = `FECS_D_SUSPEND;
      FECS_OP_RESUME:     ud = `FECS_D_RESUME;
      FECS_OP_BUF_LOAD:
        case (s_r.idx)
          3'd0: begin ua = `FECS_ADDR_UNLOCK1; ud = `FECS_D_UNLOCK1; end
          3'd1: begin ua = `FECS_ADDR_UNLOCK2; ud = `FECS_D_UNLOCK2; end
          3'd2: begin raw = 1'b1; ud = `FECS_D_BUF_LOAD; end
          default: raw = 1'b1;                                    // count
        endcase
      FECS_OP_BUF_WORD,
      FECS_OP_BYP_PROG:
        if (s_r.op == FECS_OP_BYP_PROG && s_r.idx == 3'd0)
          ud = `FECS_D_BYP_PROG;
        else
          raw = 1'b1;
      FECS_OP_BUF_COMMIT: begin raw = 1'b1; ud = `FECS_D_BUF_COMMIT; end
      FECS_OP_BYP_EXIT:
        ud = (s_r.idx == 3'd0) ? `FECS_D_IDENT : `FECS_D_ZERO;
      FECS_OP_BUF_ABORT, FECS_OP_BYP_ENTER, FECS_OP_SEC_ENTER,
      FECS_OP_SEC_EXIT, FECS_OP_PROT_VERIFY:
        case (s_r.idx)
          3'd0: begin ua = `FECS_ADDR_UNLOCK1; ud = `FECS_D_UNLOCK1; end
          3'd1: begin ua = `FECS_ADDR_UNLOCK2; ud = `FECS_D_UNLOCK2; end
          3'd2:
          begin
            ua = `FECS_ADDR_UNLOCK1;
            case (s_r.op)
              FECS_OP_BUF_ABORT: ud = `FECS_D_RESET;
              FECS_OP_BYP_ENTER: ud = `FECS_D_BYPASS;
              FECS_OP_SEC_ENTER: ud = `FECS_D_SECURE;
              default:           ud = `FECS_D_IDENT;
            endcase
          end
          default:
            if (s_r.op == FECS_OP_PROT_VERIFY)
            begin
              // sector field plus offset 02, read cycle
              bc_rd = 1'b1;
              raw   = 1'b1;
            end
            else
              ud = `FECS_D_ZERO;
        endcase
      FECS_OP_READ: begin raw = 1'b1; bc_rd = 1'b1; end
      default: ;
    endcase
    if (raw)
    begin
      bc_addr = s_r.addr;
      if (s_r.op == FECS_OP_PROT_VERIFY)
        bc_addr = {s_r.addr[AW-1:`FECS_SECT_LSB], {`FECS_SECT_LSB{1'b0}}}
                  | AW'(`FECS_OFS_PROT);
      bc_data = (s_r.op == FECS_OP_ERASE || s_r.op == FECS_OP_ADD_SECT ||
                 s_r.op == FECS_OP_BUF_COMMIT ||
                 (s_r.op == FECS_OP_BUF_LOAD && s_r.idx == 3'd2))
                ? DW'(ud) : s_r.wdata;
    end
    else
    begin
      bc_addr = AW'(ua);                                          // high bits zero
      bc_data = DW'(ud);
    end
  end

  // sequence length for each op
  function automatic logic [2:0] fecs_len(input fecs_op_t op);
    case (op)
      FECS_OP_ERASE:       fecs_len = 3'd6;
      FECS_OP_BUF_LOAD:    fecs_len = 3'd4;
      FECS_OP_BUF_ABORT,
      FECS_OP_BYP_ENTER,
      FECS_OP_SEC_ENTER:   fecs_len = 3'd3;
      FECS_OP_SEC_EXIT,
      FECS_OP_PROT_VERIFY: fecs_len = 3'd4;
      FECS_OP_BYP_PROG,
      FECS_OP_BYP_EXIT:    fecs_len = 3'd2;
      default:             fecs_len = 3'd1;
    endcase
  endfunction : fecs_len

  // request sequencing and window tracking
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    bc_go      = 1'b0;
    if (s_r.win)
    begin
      if (s_r.gap == 16'(GAP_CYC))
        s_nxt.win = 1'b0;
      else
        s_nxt.gap = s_r.gap + 16'h1;
    end
    case (s_r.st)
      ST_IDLE:
        if (i_req)
        begin
          s_nxt.op    = i_op;
          s_nxt.addr  = i_addr;
          s_nxt.wdata = i_wdata;
          s_nxt.idx   = 3'd0;
          s_nxt.len   = fecs_len(i_op);
          s_nxt.late  = (i_op == FECS_OP_ADD_SECT) && !s_r.win;
          // anything but add ends the window, suspend included
          if (i_op != FECS_OP_ADD_SECT && i_op != FECS_OP_SUSPEND)
            s_nxt.win = 1'b0;
          if (i_op == FECS_OP_SUSPEND)
            s_nxt.win = 1'b0;
          s_nxt.st = ST_ISSUE;
        end
      ST_ISSUE:
      begin
        bc_go    = 1'b1;
        s_nxt.st = ST_WAIT;
      end
      ST_WAIT:
        if (bc_done)
        begin
          if (bc_rd)
            s_nxt.rdata = bc_rdata;
          if (s_r.idx == s_r.len - 3'd1)
          begin
            // window counted from the done pulse of the last write cycle
            if (s_r.op == FECS_OP_ERASE || s_r.op == FECS_OP_ADD_SECT)
            begin
              s_nxt.win = !s_r.late;
              s_nxt.gap = '0;
            end
            s_nxt.st = ST_FIN;
          end
          else
          begin
            s_nxt.idx = s_r.idx + 3'd1;
            s_nxt.st  = ST_ISSUE;
          end
        end
      ST_FIN:
      begin
        s_nxt.done = 1'b1;
        s_nxt.st   = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // ready follows the next state so the output stays a plain flop
    s_nxt.rdy = (s_nxt.st == ST_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_r    <= '0;
      s_r.st <= ST_IDLE;
      s_r.op <= FECS_OP_READ;
      s_r.rdy <= 1'b1;
    end
    else if (i_ce)
      s_r <= s_nxt;
  end

  fecs_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_go      (bc_go),
    .i_rd      (bc_rd),
    .i_addr    (bc_addr),
    .i_data    (bc_data),
    .i_dq_in   (i_dq_in),
    .o_busy    (),
    .o_done    (bc_done),
    .o_rdata   (bc_rdata),
    .o_addr    (o_flash_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe   (o_dq_oe),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n)
  );

  assign o_ready  = s_r.rdy;
  assign o_done   = s_r.done;
  assign o_late   = s_r.late;
  assign o_rdata  = s_r.rdata;
  assign o_window = s_r.win;
endmodule : fecs_host

// file: fecs_host_asserts.sv
`timescale 1ns/1ps
// port-level property checks on the host controller
module fecs_host_asserts
  import fecs_pkg::*;
#(
  parameter int GAP_CYC = 40
)(
  input  wire logic        i_clk_sys,    // clock
  input  wire logic        i_rstn,       // reset, low
  input  wire logic        i_ce,         // clock enable
  input  wire logic        i_req,        // request
  input  wire logic        o_ready,      // idle
  input  wire logic        o_done,       // end pulse
  input  wire logic        o_window,     // window open
  input  wire logic        o_late,       // late add
  input  wire logic [21:0] o_flash_addr, // address pins
  input  wire logic [15:0] o_dq_out,     // data out
  input  wire logic        o_dq_oe,      // data driven
  input  wire logic        o_we_n,       // write enable
  input  wire logic        o_oe_n        // output enable
);
  logic [15:0] win_cnt_r;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // length of the current open window; a finished erase write restarts it
  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn) win_cnt_r <= '0;
    else win_cnt_r <= (o_window && !o_done) ? win_cnt_r + 16'h0001 : '0;
  a_done_then_ready: assert property (o_done && i_ce |-> o_ready ##1 !o_done)
    else $error("done not a single pulse with ready");
  a_accept_busy: assert property (o_ready && i_req && i_ce |=> !o_ready)
    else $error("request not taken");
  a_idle_pins: assert property (o_ready |-> o_we_n && o_oe_n && !o_dq_oe)
    else $error("pins active while idle");
  a_we_pulse: assert property ($fell(o_we_n) |-> !o_we_n [*3] ##1 o_we_n [*2])
    else $error("write pulse shape wrong");
  a_read_pulse: assert property ($fell(o_oe_n) |-> (!o_oe_n && !o_dq_oe) [*4] ##1 o_oe_n)
    else $error("read strobe shape wrong");
  a_write_hold: assert property (!o_we_n && !$past(o_we_n) |->
    $stable(o_flash_addr) && $stable(o_dq_out) && o_dq_oe)
    else $error("address or data moved during write");
  a_no_overlap: assert property (!(!o_we_n && !o_oe_n))
    else $error("write and read strobes overlap");
  a_win_bound: assert property (win_cnt_r <= GAP_CYC + 2)
    else $error("window held open too long");
  a_suspend_closes: assert property (!o_we_n && o_dq_out == 16'h00B0 &&
    o_flash_addr == 22'h000000 |-> !o_window)
    else $error("window open during suspend write");
  c_late: cover property ($rose(o_late));
  c_window: cover property ($rose(o_window));
  c_read: cover property ($fell(o_oe_n));
endmodule : fecs_host_asserts

// file: fecs_params.svh
`ifndef FECS_PARAMS_SVH
`define FECS_PARAMS_SVH
// unlock addresses and command data (word mode)
`define FECS_ADDR_UNLOCK1   12'h555
`define FECS_ADDR_UNLOCK2   12'h2AA
`define FECS_ADDR_ANY       12'h000
`define FECS_D_UNLOCK1      8'hAA
`define FECS_D_UNLOCK2      8'h55
`define FECS_D_ERASE_SETUP  8'h80
`define FECS_D_SECT_ERASE   8'h30
`define FECS_D_RESUME       8'h30
`define FECS_D_SUSPEND      8'hB0
`define FECS_D_BUF_LOAD     8'h25
`define FECS_D_BUF_COMMIT   8'h29
`define FECS_D_RESET        8'hF0
`define FECS_D_BYPASS       8'h20
`define FECS_D_BYP_PROG     8'hA0
`define FECS_D_IDENT        8'h90
`define FECS_D_ZERO         8'h00
`define FECS_D_SECURE       8'h88
// identification-mode read offset for sector-group protect verify
`define FECS_OFS_PROT       12'h002
// sector address field position
`define FECS_SECT_LSB       15
// timing: acceptance window 50 us, host spacing kept below it
`define FECS_CLK_MHZ        25
`define FECS_WIN_US         50
`define FECS_WIN_CYC        (`FECS_WIN_US * `FECS_CLK_MHZ)
// host spaces added sectors by at most half the window
`define FECS_GAP_CYC        (`FECS_WIN_CYC / 2)
// write pulse low and recovery, in cycles
`define FECS_WE_LOW_CYC     3
`define FECS_WE_HIGH_CYC    2
`define FECS_RD_CYC         4
`endif

// file: fecs_pkg.sv
package fecs_pkg;
  // user-side operations
  typedef enum logic [3:0] {
    FECS_OP_ERASE,      // six-cycle sector erase
    FECS_OP_ADD_SECT,   // add sector in window
    FECS_OP_SUSPEND,
    FECS_OP_RESUME,
    FECS_OP_BUF_LOAD,   // four header writes of buffer load
    FECS_OP_BUF_WORD,   // one location/data write
    FECS_OP_BUF_COMMIT,
    FECS_OP_BUF_ABORT,
    FECS_OP_BYP_ENTER,
    FECS_OP_BYP_PROG,
    FECS_OP_BYP_EXIT,
    FECS_OP_SEC_ENTER,
    FECS_OP_SEC_EXIT,
    FECS_OP_PROT_VERIFY,
    FECS_OP_READ
  } fecs_op_t;
endpackage : fecs_pkg

// file: flash_erase_command_sequencer_bench.sv
`timescale 1ns/1ps
module flash_erase_command_sequencer_bench import fecs_pkg::*;;
  localparam int         GAP   = 40;
  localparam logic [6:0] PSECT = 7'h0C;
  logic        i_clk_sys, i_rstn, i_req, o_ready, o_done, o_late, o_window;
  logic        o_dq_oe, o_we_n, o_oe_n, i_ce;
  fecs_op_t    i_op;
  logic [21:0] i_addr, o_flash_addr;
  logic [15:0] i_wdata, dq_in, o_rdata, o_dq_out;
  logic [21:0] ea[$];
  logic [15:0] ed[$];
  int          err_total, checks_done, cycles;
  fecs_host #(.GAP_CYC(GAP)) dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_dq_in(dq_in), .o_ready(o_ready),
    .o_done(o_done), .o_late(o_late), .o_rdata(o_rdata), .o_window(o_window),
    .o_flash_addr(o_flash_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n));
  fecs_flash_model #(.PROT_SECT(PSECT)) flash (
    .i_addr(o_flash_addr), .i_dq(o_dq_out), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .o_dq(dq_in));
  // clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // hang guard
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [21:0] sector_addr(input logic [6:0] s);
    return {s, 15'h0000};
  endfunction : sector_addr
  function automatic logic [15:0] arr(input logic [21:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction : arr
  task automatic ew(input logic [21:0] a, input logic [15:0] d);
    ea.push_back(a);
    ed.push_back(d);
  endtask : ew
  task automatic u3(input logic [15:0] c);
    ew(22'h000555, 16'h00AA);
    ew(22'h0002AA, 16'h0055);
    ew(22'h000555, c);
  endtask : u3
  task automatic es(input logic [6:0] s);
    u3(16'h0080);
    u3(16'h0000);
    ed[5] = 16'h0030;
    ea[5] = sector_addr(s);
  endtask : es
  // one operation; compares the pin writes seen by the device
  task automatic run(input fecs_op_t op, input logic [21:0] a, input logic [15:0] d);
    int n;
    flash.wa.delete();
    flash.wd.delete();
    flash.ra.delete();
    while (o_ready !== 1'b1) @(posedge i_clk_sys) #1;
    i_op = op;
    i_addr = a;
    i_wdata = d;
    i_req = 1'b1;
    @(posedge i_clk_sys) #1;
    i_req = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 400)
    begin
      @(posedge i_clk_sys) #1;
      n++;
    end
    check(n < 400, 1);
    check(flash.wa.size(), ea.size());
    for (int i = 0; i < ea.size(); i++)
    begin
      check(flash.wa[i], ea[i]);
      check(flash.wd[i], ed[i]);
    end
    ea.delete();
    ed.delete();
  endtask : run
  task automatic t_reset();
    check({o_ready, o_done, o_late, o_window, o_dq_oe, o_we_n, o_oe_n}, 7'h43);
  endtask : t_reset
  // clock enable low freezes the controller: a request is not taken
  task automatic t_hold();
    i_ce = 1'b0;
    i_op = FECS_OP_SUSPEND;
    i_req = 1'b1;
    repeat (3) @(posedge i_clk_sys) #1;
    check({o_ready, o_we_n, o_done}, 3'b110);
    i_req = 1'b0;
    i_ce = 1'b1;
    @(posedge i_clk_sys) #1;
    check(o_ready, 1);
  endtask : t_hold
  task automatic t_buffer();
    u3(16'h0000);
    ea[2] = sector_addr(7'h02);
    ed[2] = 16'h0025;
    ew(sector_addr(7'h02), 16'h0001);
    run(FECS_OP_BUF_LOAD, sector_addr(7'h02), 16'h0001);
    for (int k = 4; k < 6; k++)
    begin
      ew(sector_addr(7'h02) | k, 16'hAB00 | k);
      run(FECS_OP_BUF_WORD, sector_addr(7'h02) | k, 16'hAB00 | k);
    end
    ew(sector_addr(7'h02), 16'h0029);
    run(FECS_OP_BUF_COMMIT, sector_addr(7'h02), 16'h0000);
    u3(16'h00F0);
    run(FECS_OP_BUF_ABORT, 22'h000000, 16'h0000);
  endtask : t_buffer
  task automatic t_modes();
    u3(16'h0020);
    run(FECS_OP_BYP_ENTER, 22'h000000, 16'h0000);
    ew(22'h000000, 16'h00A0);
    ew(22'h012345, 16'hBEEF);
    run(FECS_OP_BYP_PROG, 22'h012345, 16'hBEEF);
    ew(22'h000000, 16'h0090);
    ew(22'h000000, 16'h0000);
    run(FECS_OP_BYP_EXIT, 22'h000000, 16'h0000);
    u3(16'h0088);
    run(FECS_OP_SEC_ENTER, 22'h000000, 16'h0000);
    u3(16'h0090);
    ew(22'h000000, 16'h0000);
    run(FECS_OP_SEC_EXIT, 22'h000000, 16'h0000);
  endtask : t_modes
  task automatic t_protect(input logic [6:0] s);
    u3(16'h0090);
    run(FECS_OP_PROT_VERIFY, sector_addr(s) | 22'h000123, 16'h0000);
    check(flash.ra[0], sector_addr(s) | 22'h000002);
    check(o_rdata, s == PSECT);
    u3(16'h00F0);
    run(FECS_OP_BUF_ABORT, 22'h000000, 16'h0000);
  endtask : t_protect
  task automatic t_erase();
    int n;
    es(7'h05);
    run(FECS_OP_ERASE, sector_addr(7'h05), 16'h0000);
    check(o_window, 1);
    ew(sector_addr(7'h09), 16'h0030);
    run(FECS_OP_ADD_SECT, sector_addr(7'h09), 16'h0000);
    check({o_late, o_window}, 2'b01);
    for (n = 0; o_window === 1'b1 && n < 100; n++) @(posedge i_clk_sys) #1;
    check(o_window, 0);
    ew(sector_addr(7'h0A), 16'h0030);
    run(FECS_OP_ADD_SECT, sector_addr(7'h0A), 16'h0000);
    check(o_late, 1);
    repeat (300) @(posedge i_clk_sys) #1;
    run(FECS_OP_READ, sector_addr(7'h05) | 22'h000123, 16'h0000);
    check(o_rdata, arr(sector_addr(7'h05) | 22'h000123));
  endtask : t_erase
  task automatic t_suspend();
    es(7'h03);
    run(FECS_OP_ERASE, sector_addr(7'h03), 16'h0000);
    ew(22'h000000, 16'h00B0);
    run(FECS_OP_SUSPEND, 22'h000000, 16'h0000);
    check(o_window, 0);
    // suspended sector answers status: polling low, timer bit set
    run(FECS_OP_READ, sector_addr(7'h03), 16'h0000);
    check(o_rdata & 16'hFFBB, 16'h0008);
    run(FECS_OP_READ, sector_addr(7'h01) | 22'h000007, 16'h0000);
    check(o_rdata, arr(sector_addr(7'h01) | 22'h000007));
    t_protect(PSECT);
    repeat (2)
    begin
      ew(22'h000000, 16'h0030);
      run(FECS_OP_RESUME, 22'h000000, 16'h0000);
    end
  endtask : t_suspend
  // main sequence
  initial
  begin
    i_rstn = 1'b0;
    i_req = 1'b0;
    i_ce = 1'b1;
    i_op = FECS_OP_READ;
    i_addr = '0;
    i_wdata = '0;
    repeat (4) @(posedge i_clk_sys);
    #1 i_rstn = 1'b1;
    t_reset();
    t_hold();
    t_buffer();
    t_modes();
    t_protect(PSECT);
    t_protect(7'h11);
    t_erase();
    t_suspend();
    tally_and_finish();
  end
endmodule : flash_erase_command_sequencer_bench
bind fecs_host fecs_host_asserts #(.GAP_CYC(GAP_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_req(i_req), .o_ready(o_ready),
  .o_done(o_done), .o_window(o_window), .o_late(o_late), .o_flash_addr(o_flash_addr),
  .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_we_n(o_we_n), .o_oe_n(o_oe_n));
